// ### cea_access.sv
// Configuration memory access unit: control word, address and data registers,
// emulation handshake with the local host and reload distribution.
// Assumes two 16-bit register ports on the same clock, even byte addresses.
`timescale 1ns/1ps
module cea_access
  import cea_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Network side register port
  input wire logic net_wr_i,
  input wire logic net_rd_i,
  input wire logic [15:0] net_addr_i,
  input wire logic [1:0] net_be_i,
  input wire logic [15:0] net_wdata_i,
  output logic [15:0] net_rdata_o,
  input wire logic net_sof_i,
  // Local host interface register port
  input wire logic lhi_wr_i,
  input wire logic lhi_rd_i,
  input wire logic [15:0] lhi_addr_i,
  input wire logic [1:0] lhi_be_i,
  input wire logic [15:0] lhi_wdata_i,
  output logic [15:0] lhi_rdata_o,
  input wire logic lhi_owns_i,
  // Configuration
  input wire logic emul_mode_i,
  input wire logic read8_i,
  input wire logic two_byte_i,
  // Serial memory engine
  output logic eng_start_o,
  output logic [2:0] eng_cmd_o,
  output logic [31:0] eng_addr_o,
  output logic [15:0] eng_wdata_o,
  input wire logic eng_done_i,
  input wire logic eng_nack_i,
  input wire logic eng_crc_err_i,
  input wire logic [63:0] eng_rdata_i,
  // Events and reload targets
  output logic app_layer_event_request_o,
  output logic [15:0] station_alias_o,
  output logic eld_all_o,
  output logic [3:0] eld_port_o,
  output logic [3:0] dl_cfg_o,
  output logic [2:0] dl_fifo_size_o
);

  typedef struct packed {
    logic we;
    logic [2:0] cmd;
    logic crc_err;
    logic not_loaded;
    logic ack_err;
    logic we_err;
    logic busy;
    logic [31:0] addr;
    logic [63:0] data;
    logic evt_req;
    logic start;
    logic reload;
    logic [15:0] net_rdata;
    logic [15:0] lhi_rdata;
  } cea_state_t;

  cea_state_t st_ff;
  cea_state_t nxt_st;

  cea_reload_if rld_if ();

  // ==========================================================================
  // Port arrays: index 0 network side, index 1 local host
  logic [1:0] wr_v;
  logic [1:0] rd_v;
  logic [1:0] own_v;
  logic [15:0] addr_v [2];
  logic [1:0] be_v [2];
  logic [15:0] wd_v [2];
  logic we_eff;

  assign wr_v = {lhi_wr_i, net_wr_i};
  assign rd_v = {lhi_rd_i, net_rd_i};
  assign own_v = {lhi_owns_i, ~lhi_owns_i};
  assign addr_v[0] = net_addr_i;
  assign addr_v[1] = lhi_addr_i;
  assign be_v[0] = net_be_i;
  assign be_v[1] = lhi_be_i;
  assign wd_v[0] = net_wdata_i;
  assign wd_v[1] = lhi_wdata_i;
  // Write enable reads as one whenever the local host holds the interface
  assign we_eff = st_ff.we | lhi_owns_i;

  // ==========================================================================
  // Control word assembly
  function automatic logic [15:0] ctrl_word(input cea_state_t s, input logic we,
                                            input logic emul, input logic rd8,
                                            input logic algo);
    logic [15:0] w;
    w = 16'h0000;
    w[CEA_CTRL_WE] = we;
    w[CEA_CTRL_EMUL] = emul;
    w[CEA_CTRL_RD8] = rd8;
    w[CEA_CTRL_ALGO] = algo;
    w[CEA_CTRL_CMD_MSB:CEA_CTRL_CMD_LSB] = s.cmd;
    w[CEA_CTRL_CRC_ERR] = s.crc_err;
    w[CEA_CTRL_NOT_LOADED] = s.not_loaded;
    w[CEA_CTRL_ACK_ERR] = s.ack_err;
    w[CEA_CTRL_WE_ERR] = s.we_err;
    w[CEA_CTRL_BUSY] = s.busy;
    ctrl_word = w;
  endfunction : ctrl_word

  // Read mux shared by both ports; unmapped addresses read as zero
  function automatic logic [15:0] read_mux(input cea_state_t s, input logic [15:0] a,
                                           input logic [15:0] cw);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      CEA_OFS_CTRL: r = cw;
      CEA_OFS_ADDR_LO: r = s.addr[15:0];
      CEA_OFS_ADDR_HI: r = s.addr[31:16];
      CEA_OFS_DATA0: r = s.data[15:0];
      CEA_OFS_DATA1: r = s.data[31:16];
      CEA_OFS_DATA2: r = s.data[47:32];
      CEA_OFS_DATA3: r = s.data[63:48];
      default: r = 16'h0000;
    endcase
    read_mux = r;
  endfunction : read_mux

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic reg_ok;
    logic emu_ok;
    logic data_ok;
    logic [2:0] c;
    logic [15:0] cw;
    logic [1:0] di;
    reg_ok = 1'b0;
    emu_ok = 1'b0;
    data_ok = 1'b0;
    c = CEA_CMD_IDLE;
    di = 2'h0;
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.reload = 1'b0;
    cw = ctrl_word(st_ff, we_eff, emul_mode_i, read8_i, two_byte_i);

    // Frame start drops write permission; a network-side write of the enable bit in the same cycle re-arms it
    if (net_sof_i) begin
      nxt_st.we = 1'b0;
    end

    for (int i = 0; i < 2; i++) begin
      // Owner may write only while idle; emulating host only while busy
      reg_ok = own_v[i] && !st_ff.busy;
      emu_ok = (i == 1) && emul_mode_i && st_ff.busy;
      data_ok = emu_ok && ((st_ff.cmd == CEA_CMD_READ) || (st_ff.cmd == CEA_CMD_RELOAD));
      c = wd_v[i][CEA_CTRL_CMD_MSB:CEA_CTRL_CMD_LSB];
      di = addr_v[i][2:1];
      if (wr_v[i]) begin
        case (addr_v[i])
          CEA_OFS_CTRL: begin
            if (reg_ok && (i == 0) && be_v[i][0]) begin
              nxt_st.we = wd_v[i][CEA_CTRL_WE];
            end
            if (reg_ok && be_v[i][1]) begin
              if (c == CEA_CMD_IDLE) begin
                nxt_st.ack_err = 1'b0;
                nxt_st.we_err = 1'b0;
              end else if (st_ff.ack_err) begin
                // Pending acknowledge error locks out new commands until idle is written
                nxt_st.cmd = st_ff.cmd;
              end else if (cea_cmd_valid(c)) begin
                nxt_st.ack_err = 1'b0;
                nxt_st.we_err = 1'b0;
                if ((c == CEA_CMD_WRITE) && !we_eff) begin
                  nxt_st.we_err = 1'b1;
                end else begin
                  nxt_st.busy = 1'b1;
                  nxt_st.cmd = c;
                  if (c == CEA_CMD_RELOAD) begin
                    nxt_st.not_loaded = 1'b1;
                  end
                  if (emul_mode_i) begin
                    nxt_st.evt_req = 1'b1;
                  end else begin
                    nxt_st.start = 1'b1;
                  end
                end
              end else begin
                nxt_st.ack_err = 1'b1;
              end
            end else if (emu_ok && be_v[i][1]) begin
              // Acknowledge: ones written over the pending command bits
              if ((c & st_ff.cmd) != CEA_CMD_IDLE) begin
                nxt_st.busy = 1'b0;
                nxt_st.cmd = CEA_CMD_IDLE;
                nxt_st.evt_req = 1'b0;
                if (st_ff.cmd == CEA_CMD_RELOAD) begin
                  nxt_st.reload = 1'b1;
                  nxt_st.not_loaded = wd_v[i][CEA_CTRL_CRC_ERR];
                end
              end
              if (wd_v[i][CEA_CTRL_ACK_ERR]) begin
                nxt_st.ack_err = 1'b1;
              end
              if (wd_v[i][CEA_CTRL_CRC_ERR]) begin
                nxt_st.crc_err = 1'b1;
              end
            end
          end
          // Word address, no byte scaling applied
          CEA_OFS_ADDR_LO: begin
            if (reg_ok) begin
              nxt_st.addr[15:0] = cea_merge16(st_ff.addr[15:0], wd_v[i], be_v[i]);
            end
          end
          CEA_OFS_ADDR_HI: begin
            if (reg_ok) begin
              nxt_st.addr[31:16] = cea_merge16(st_ff.addr[31:16], wd_v[i], be_v[i]);
            end
          end
          CEA_OFS_DATA0, CEA_OFS_DATA1, CEA_OFS_DATA2, CEA_OFS_DATA3: begin
            // Owner reaches only the low word; upper words hold read data
            if ((reg_ok && (di == 2'h0)) || data_ok) begin
              nxt_st.data[16*di +: 16] = cea_merge16(st_ff.data[16*di +: 16], wd_v[i], be_v[i]);
            end
          end
          default: begin
            nxt_st.busy = nxt_st.busy;
          end
        endcase
      end
    end

    // Engine completion in normal operation; host writes are blocked meanwhile
    if (eng_done_i && st_ff.busy && !emul_mode_i) begin
      nxt_st.busy = 1'b0;
      nxt_st.cmd = CEA_CMD_IDLE;
      if (eng_nack_i) begin
        nxt_st.ack_err = 1'b1;
      end
      if ((st_ff.cmd == CEA_CMD_READ) || (st_ff.cmd == CEA_CMD_RELOAD)) begin
        nxt_st.data = eng_rdata_i;
      end
      if (st_ff.cmd == CEA_CMD_RELOAD) begin
        nxt_st.crc_err = eng_crc_err_i;
        nxt_st.not_loaded = eng_crc_err_i | eng_nack_i;
        nxt_st.reload = !eng_nack_i;
      end
    end

    // Registered read data, one cycle after the read strobe
    if (rd_v[0]) begin
      nxt_st.net_rdata = read_mux(st_ff, net_addr_i, cw);
    end
    if (rd_v[1]) begin
      nxt_st.lhi_rdata = read_mux(st_ff, lhi_addr_i, cw);
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{we: 1'b0, cmd: CEA_CMD_IDLE, crc_err: 1'b0, not_loaded: 1'b0,
                 ack_err: 1'b0, we_err: 1'b0, busy: 1'b0, addr: CEA_ADDR_RST,
                 data: CEA_DATA_RST, evt_req: 1'b0, start: 1'b0, reload: 1'b0,
                 net_rdata: 16'h0000, lhi_rdata: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign net_rdata_o = st_ff.net_rdata;
  assign lhi_rdata_o = st_ff.lhi_rdata;
  assign app_layer_event_request_o = st_ff.evt_req;

  // ==========================================================================
  // Reload distribution, image taken one cycle after acknowledge
  assign rld_if.load = st_ff.reload;
  assign rld_if.image = st_ff.data[31:0];

  cea_reload_dist u_reload (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .rld(rld_if),
    .station_alias_o(station_alias_o),
    .eld_all_o(eld_all_o),
    .eld_port_o(eld_port_o),
    .dl_cfg_o(dl_cfg_o),
    .dl_fifo_size_o(dl_fifo_size_o)
  );

  // ==========================================================================
  // Engine request; never started in emulation
  cea_eng_req u_req (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(st_ff.start),
    .cmd_i(st_ff.cmd),
    .addr_i(st_ff.addr),
    .wdata_i(st_ff.data[15:0]),
    .two_byte_i(two_byte_i),
    .eng_start_o(eng_start_o),
    .eng_cmd_o(eng_cmd_o),
    .eng_addr_o(eng_addr_o),
    .eng_wdata_o(eng_wdata_o)
  );

endmodule : cea_access

// ### cea_access_checker.sv
// Port-level assertions for the configuration memory access unit.
// Assumes one clock; bound into every cea_access instance.
`timescale 1ns/1ps
module cea_access_checker
  import cea_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic net_wr_i,
  input wire logic net_rd_i,
  input wire logic [15:0] net_addr_i,
  input wire logic [15:0] net_rdata_o,
  input wire logic lhi_wr_i,
  input wire logic [15:0] lhi_addr_i,
  input wire logic [1:0] lhi_be_i,
  input wire logic [15:0] lhi_wdata_i,
  input wire logic emul_mode_i,
  input wire logic two_byte_i,
  input wire logic eng_start_o,
  input wire logic [31:0] eng_addr_o,
  input wire logic eng_done_i,
  input wire logic app_layer_event_request_o,
  input wire logic [15:0] station_alias_o,
  input wire logic [2:0] dl_fifo_size_o
);
  // ==========================================================================
  // Helper: a first load has moved the FIFO size off its reset value
  logic fifo_seen_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) fifo_seen_ff <= 1'b0;
    else if (dl_fifo_size_o != CEA_FIFO_RST) fifo_seen_ff <= 1'b1;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================================
  // Acknowledge sequence: host writes all three command bits
  sequence s_ack;
    lhi_wr_i && lhi_addr_i == CEA_OFS_CTRL && lhi_be_i[1] && lhi_wdata_i[10:8] == 3'h7;
  endsequence
  sequence s_pend;
    app_layer_event_request_o && !net_wr_i;
  endsequence

  chk_evt_clear: assert property (s_pend ##0 s_ack |=> !app_layer_event_request_o)
    else $error("event request survived acknowledge");
  chk_evt_cause: assert property ($rose(app_layer_event_request_o) |-> $past(net_wr_i))
    else $error("event request rose without a command write");
  chk_evt_emul: assert property (app_layer_event_request_o |-> emul_mode_i)
    else $error("event request outside emulation");
  chk_eng_normal: assert property (eng_start_o |-> !emul_mode_i)
    else $error("engine started in emulation");
  chk_addr_small: assert property (eng_start_o && !two_byte_i |-> eng_addr_o[31:10] == 22'h0)
    else $error("small memory address not masked to 10 bits");
  chk_addr_large: assert property (eng_start_o && two_byte_i |-> eng_addr_o[31:18] == 14'h0)
    else $error("large memory address not masked to 18 bits");
  chk_rdata_hold: assert property ($past(rst_b_i) && !$past(net_rd_i) |-> $stable(net_rdata_o))
    else $error("read data changed without a read");
  chk_rdata_unmap: assert property (net_rd_i && net_addr_i == 16'h0600 |=> net_rdata_o == 16'h0)
    else $error("unmapped read not zero");
  chk_reload_lag: assert property ($changed(station_alias_o) && $past(rst_b_i)
    |-> $past(lhi_wr_i, 2) || $past(eng_done_i, 2))
    else $error("alias changed without a reload completion");
  chk_fifo_once: assert property (fifo_seen_ff |-> $stable(dl_fifo_size_o))
    else $error("FIFO size changed after first load");
endmodule : cea_access_checker

bind cea_access cea_access_checker cea_access_checker_i (.*);

// ### cea_eng_model.sv
// Behavioural serial memory engine answering each start after four cycles.
// Assumes start is a one-cycle pulse; read data only meaningful with done.
`timescale 1ns/1ps
module cea_eng_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic eng_start_i,
  output logic eng_done_o,
  output logic [63:0] eng_rdata_o
);
  localparam logic [63:0] PAT = 64'h0123_4567_89AB_CDEF;
  logic [2:0] cnt_ff;
  // ==========================================================================
  // Countdown from start to done
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) cnt_ff <= 3'h0;
    else if (eng_start_i) cnt_ff <= 3'h4;
    else if (cnt_ff != 3'h0) cnt_ff <= cnt_ff - 3'h1;
  end
  assign eng_done_o = (cnt_ff == 3'h1);
  // Inverse outside done, so stale data never passes for fresh
  assign eng_rdata_o = eng_done_o ? PAT : ~PAT;
endmodule : cea_eng_model

// ### cea_eng_req.sv
// Request register toward the serial memory engine.
// Assumes the engine latches the request on the start pulse.
`timescale 1ns/1ps
module cea_eng_req
  import cea_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [2:0] cmd_i,
  input wire logic [31:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic two_byte_i,
  output logic eng_start_o,
  output logic [2:0] eng_cmd_o,
  output logic [31:0] eng_addr_o,
  output logic [15:0] eng_wdata_o
);

  typedef struct packed {
    logic start;
    logic [2:0] cmd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } cea_req_state_t;

  cea_req_state_t st_ff;
  cea_req_state_t nxt_st;

  // ==========================================================================
  // Address width follows the memory size; upper bits never reach the engine
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = start_i;
    if (start_i) begin
      nxt_st.cmd = cmd_i;
      nxt_st.wdata = wdata_i;
      nxt_st.addr = two_byte_i ? {14'h0000, addr_i[17:0]} : {22'h000000, addr_i[9:0]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{start: 1'b0, cmd: CEA_CMD_IDLE, addr: CEA_ADDR_RST, wdata: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign eng_start_o = st_ff.start;
  assign eng_cmd_o = st_ff.cmd;
  assign eng_addr_o = st_ff.addr;
  assign eng_wdata_o = st_ff.wdata;

endmodule : cea_eng_req

// ### cea_pkg.sv
// Constants for the configuration memory access unit.
// Assumes byte addresses on a 16-bit register port, even addresses only.
package cea_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [15:0] CEA_OFS_CTRL = 16'h0502;
  localparam logic [15:0] CEA_OFS_ADDR_LO = 16'h0504;
  localparam logic [15:0] CEA_OFS_ADDR_HI = 16'h0506;
  localparam logic [15:0] CEA_OFS_DATA0 = 16'h0508;
  localparam logic [15:0] CEA_OFS_DATA1 = 16'h050A;
  localparam logic [15:0] CEA_OFS_DATA2 = 16'h050C;
  localparam logic [15:0] CEA_OFS_DATA3 = 16'h050E;

  // ==========================================================================
  // Control word bit positions
  localparam int CEA_CTRL_WE = 0;
  localparam int CEA_CTRL_EMUL = 5;
  localparam int CEA_CTRL_RD8 = 6;
  localparam int CEA_CTRL_ALGO = 7;
  localparam int CEA_CTRL_CMD_LSB = 8;
  localparam int CEA_CTRL_CMD_MSB = 10;
  localparam int CEA_CTRL_CRC_ERR = 11;
  localparam int CEA_CTRL_NOT_LOADED = 12;
  localparam int CEA_CTRL_ACK_ERR = 13;
  localparam int CEA_CTRL_WE_ERR = 14;
  localparam int CEA_CTRL_BUSY = 15;

  // ==========================================================================
  // Command codes
  localparam logic [2:0] CEA_CMD_IDLE = 3'h0;
  localparam logic [2:0] CEA_CMD_READ = 3'h1;
  localparam logic [2:0] CEA_CMD_WRITE = 3'h2;
  localparam logic [2:0] CEA_CMD_RELOAD = 3'h4;

  // ==========================================================================
  // Reload image layout
  localparam int CEA_RLD_ALIAS_MSB = 15;
  localparam int CEA_RLD_ELD_ALL = 16;
  localparam int CEA_RLD_ELD_PORT_LSB = 17;
  localparam int CEA_RLD_DLCFG_LSB = 21;
  localparam int CEA_RLD_FIFO_LSB = 25;
  localparam logic [2:0] CEA_FIFO_MAX = 3'h7;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] CEA_ADDR_RST = 32'h0000_0000;
  localparam logic [63:0] CEA_DATA_RST = 64'h0000_0000_0000_0000;
  localparam logic [15:0] CEA_ALIAS_RST = 16'h0000;
  localparam logic [3:0] CEA_DLCFG_RST = 4'h0;
  localparam logic [2:0] CEA_FIFO_RST = 3'h7;

  // Only the three documented codes start a command
  function automatic logic cea_cmd_valid(input logic [2:0] c);
    cea_cmd_valid = (c == CEA_CMD_READ) || (c == CEA_CMD_WRITE) || (c == CEA_CMD_RELOAD);
  endfunction : cea_cmd_valid

  // Byte-lane merge for 16-bit register writes
  function automatic logic [15:0] cea_merge16(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0] be);
    cea_merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : cea_merge16

endpackage : cea_pkg

// ### cea_reload_dist.sv
// Target registers loaded from a reload image.
// Assumes the image is stable while load is high.
`timescale 1ns/1ps
module cea_reload_dist
  import cea_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  cea_reload_if.dst rld,
  output logic [15:0] station_alias_o,
  output logic eld_all_o,
  output logic [3:0] eld_port_o,
  output logic [3:0] dl_cfg_o,
  output logic [2:0] dl_fifo_size_o
);

  typedef struct packed {
    logic [15:0] alias_v;
    logic eld_all;
    logic [3:0] eld_port;
    logic [3:0] dl_cfg;
    logic [2:0] fifo;
    logic loaded_once;
  } cea_rld_state_t;

  cea_rld_state_t st_ff;
  cea_rld_state_t nxt_st;

  // ==========================================================================
  // Field distribution
  always_comb begin
    nxt_st = st_ff;
    if (rld.load) begin
      nxt_st.alias_v = rld.image[CEA_RLD_ALIAS_MSB:0];
      nxt_st.eld_all = rld.image[CEA_RLD_ELD_ALL];
      nxt_st.eld_port = rld.image[CEA_RLD_ELD_PORT_LSB +: 4];
      nxt_st.dl_cfg = rld.image[CEA_RLD_DLCFG_LSB +: 4];
      // Later reloads must not resize a FIFO that is already running
      if (!st_ff.loaded_once) begin
        nxt_st.fifo = CEA_FIFO_MAX - rld.image[CEA_RLD_FIFO_LSB +: 3];
      end
      nxt_st.loaded_once = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{alias_v: CEA_ALIAS_RST, eld_all: 1'b0, eld_port: 4'h0,
                 dl_cfg: CEA_DLCFG_RST, fifo: CEA_FIFO_RST, loaded_once: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign station_alias_o = st_ff.alias_v;
  assign eld_all_o = st_ff.eld_all;
  assign eld_port_o = st_ff.eld_port;
  assign dl_cfg_o = st_ff.dl_cfg;
  assign dl_fifo_size_o = st_ff.fifo;

endmodule : cea_reload_dist

// ### cea_reload_if.sv
// Carrier for the reload image from the access unit to the target registers.
// Assumes one clock domain; the strobe is a single-cycle pulse.
`timescale 1ns/1ps
interface cea_reload_if;
  logic load;
  logic [31:0] image;
  modport src (output load, output image);
  modport dst (input load, input image);
endinterface : cea_reload_if

// ### testbench.sv
// Self-checking bench for the configuration memory access unit.
// Assumes the engine model answers four cycles after a start.
`timescale 1ns/1ps
module testbench import cea_pkg::*;;
  logic clk = 1'b0, rst_b = 1'b0, net_wr = 1'b0, net_rd = 1'b0;
  logic lhi_wr = 1'b0, lhi_rd = 1'b0, sof = 1'b0, emul = 1'b1, two_b = 1'b0;
  logic own = 1'b0, r8 = 1'b0;
  logic [15:0] bus_addr = 16'h0, bus_wdata = 16'h0, net_rdata, lhi_rdata, eng_wdata, alias_v;
  logic [1:0] bus_be = 2'h0;
  logic eng_start, eng_done, evt, eld_all;
  logic [2:0] eng_cmd, fifo;
  logic [31:0] eng_addr;
  logic [63:0] eng_rdata;
  logic [3:0] eld_port, dl_cfg;
  int n_errors = 0, num_checks = 0, cyc = 0;

  cea_access cea_access_i (.ref_clk_i(clk), .rst_b_i(rst_b), .net_wr_i(net_wr),
    .net_rd_i(net_rd), .net_addr_i(bus_addr), .net_be_i(bus_be), .net_wdata_i(bus_wdata),
    .net_rdata_o(net_rdata), .net_sof_i(sof), .lhi_wr_i(lhi_wr), .lhi_rd_i(lhi_rd),
    .lhi_addr_i(bus_addr), .lhi_be_i(bus_be), .lhi_wdata_i(bus_wdata),
    .lhi_rdata_o(lhi_rdata), .lhi_owns_i(own), .emul_mode_i(emul), .read8_i(r8),
    .two_byte_i(two_b), .eng_start_o(eng_start), .eng_cmd_o(eng_cmd), .eng_addr_o(eng_addr),
    .eng_wdata_o(eng_wdata), .eng_done_i(eng_done), .eng_nack_i(1'b0),
    .eng_crc_err_i(1'b0), .eng_rdata_i(eng_rdata), .app_layer_event_request_o(evt),
    .station_alias_o(alias_v), .eld_all_o(eld_all), .eld_port_o(eld_port),
    .dl_cfg_o(dl_cfg), .dl_fifo_size_o(fifo));
  cea_eng_model cea_eng_model_i (.ref_clk_i(clk), .rst_b_i(rst_b), .eng_start_i(eng_start),
    .eng_done_o(eng_done), .eng_rdata_o(eng_rdata));

  // ==========================================================================
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  // One-cycle strobe; h selects the local host port
  task automatic wr(input bit h, input logic [15:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(posedge clk) #1;
    bus_addr = a;
    bus_be = be;
    bus_wdata = d;
    net_wr = !h;
    lhi_wr = h;
    @(posedge clk) #1;
    net_wr = 1'b0;
    lhi_wr = 1'b0;
  endtask : wr

  task automatic rd(input bit h, input logic [15:0] a, input logic [15:0] e);
    @(posedge clk) #1;
    bus_addr = a;
    net_rd = !h;
    lhi_rd = h;
    @(posedge clk) #1;
    net_rd = 1'b0;
    lhi_rd = 1'b0;
    chk($sformatf("rd %h", a), h ? lhi_rdata : net_rdata, e);
  endtask : rd

  // Emulated reload: network command, host fills image, host acknowledges
  task automatic reload(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] ack);
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0400);
    wr(1, CEA_OFS_DATA0, 2'h3, lo);
    wr(1, CEA_OFS_DATA1, 2'h3, hi);
    wr(1, CEA_OFS_CTRL, 2'h2, ack);
    repeat (3) @(posedge clk) #1;
  endtask : reload

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk) #1;
    rst_b = 1'b1;
    chk("fifo", fifo, 3'h7);
    rd(0, CEA_OFS_CTRL, 16'h0020);
    r8 = 1'b1;
    rd(0, CEA_OFS_CTRL, 16'h0060);
    r8 = 1'b0;
    rd(0, 16'h0600, 16'h0000);
    wr(0, CEA_OFS_CTRL, 2'h1, 16'h0001);
    rd(0, CEA_OFS_CTRL, 16'h0021);
    @(posedge clk) #1 sof = 1'b1;
    @(posedge clk) #1 sof = 1'b0;
    rd(0, CEA_OFS_CTRL, 16'h0020);
    // Ownership: only the owning side reaches the address register
    wr(1, CEA_OFS_ADDR_LO, 2'h3, 16'h00AA);
    rd(0, CEA_OFS_ADDR_LO, 16'h0000);
    own = 1'b1;
    wr(0, CEA_OFS_ADDR_LO, 2'h3, 16'h00BB);
    wr(1, CEA_OFS_ADDR_HI, 2'h3, 16'h00CC);
    rd(1, CEA_OFS_ADDR_HI, 16'h00CC);
    rd(1, CEA_OFS_ADDR_LO, 16'h0000);
    rd(1, CEA_OFS_CTRL, 16'h0021);
    own = 1'b0;
    // Emulated read with data placed before acknowledge
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0100);
    rd(0, CEA_OFS_CTRL, 16'h8120);
    chk("evt", evt, 1'b1);
    wr(0, CEA_OFS_ADDR_LO, 2'h3, 16'h1234);
    rd(0, CEA_OFS_ADDR_LO, 16'h0000);
    wr(1, CEA_OFS_DATA0, 2'h3, 16'hBEEF);
    wr(1, CEA_OFS_DATA1, 2'h3, 16'hCAFE);
    wr(1, CEA_OFS_CTRL, 2'h2, 16'h0700);
    @(posedge clk) #1;
    chk("evt", evt, 1'b0);
    rd(0, CEA_OFS_CTRL, 16'h0020);
    rd(0, CEA_OFS_DATA0, 16'hBEEF);
    wr(0, CEA_OFS_DATA1, 2'h3, 16'h1111);
    rd(0, CEA_OFS_DATA1, 16'hCAFE);
    // Errors: invalid code, blocked command, idle clear, host failure
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0300);
    rd(0, CEA_OFS_CTRL, 16'h2020);
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0100);
    rd(0, CEA_OFS_CTRL, 16'h2020);
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0000);
    rd(0, CEA_OFS_CTRL, 16'h0020);
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0100);
    wr(1, CEA_OFS_CTRL, 2'h2, 16'h2700);
    rd(0, CEA_OFS_CTRL, 16'h2020);
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0000);
    // Reloads: first sets every target, second must keep the FIFO size
    reload(16'h5A5A, 16'h0475, 16'h0700);
    chk("alias", alias_v, 16'h5A5A);
    chk("eld_all", eld_all, 1'b1);
    chk("eld_port", eld_port, 4'hA);
    chk("dl_cfg", dl_cfg, 4'h3);
    chk("fifo", fifo, 3'h5);
    reload(16'h00C3, 16'h0E00, 16'h0F00);
    chk("alias", alias_v, 16'h00C3);
    chk("fifo", fifo, 3'h5);
    rd(0, CEA_OFS_CTRL, 16'h1820);
    // Normal mode: engine address masked by memory size
    emul = 1'b0;
    wr(0, CEA_OFS_ADDR_LO, 2'h3, 16'h0005);
    wr(0, CEA_OFS_ADDR_HI, 2'h3, 16'h00FF);
    rd(0, CEA_OFS_ADDR_HI, 16'h00FF);
    for (int k = 1; k >= 0; k--) begin
      two_b = k[0];
      wr(0, CEA_OFS_CTRL, 2'h2, 16'h0100);
      for (int i = 0; i < 20 && eng_start !== 1'b1; i++) @(posedge clk) #1;
      chk("eng_addr", eng_addr, k ? 32'h0003_0005 : 32'h0000_0005);
      chk("eng_cmd", eng_cmd, CEA_CMD_READ);
      repeat (8) @(posedge clk) #1;
      rd(0, CEA_OFS_DATA0, 16'hCDEF);
      rd(0, CEA_OFS_DATA3, 16'h0123);
    end
    // Write command: refused without write enable, accepted with it
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0200);
    rd(0, CEA_OFS_CTRL, 16'h5800);
    wr(0, CEA_OFS_CTRL, 2'h1, 16'h0001);
    wr(0, CEA_OFS_CTRL, 2'h2, 16'h0200);
    rd(0, CEA_OFS_CTRL, 16'h9A01);
    chk("eng_cmd", eng_cmd, CEA_CMD_WRITE);
    chk("eng_wdata", eng_wdata, 16'hCDEF);
    repeat (8) @(posedge clk) #1;
    // Mid-run reset: the next reload counts as a first load again
    rst_b = 1'b0;
    repeat (3) @(posedge clk) #1;
    rst_b = 1'b1;
    chk("fifo", fifo, 3'h7);
    emul = 1'b1;
    reload(16'h0001, 16'h0200, 16'h0700);
    chk("fifo", fifo, 3'h6);
    rd(0, CEA_OFS_CTRL, 16'h0020);
    end_sim();
  end
endmodule : testbench
